// ===== ppc_peer_model.sv
// Behavioural model of the handshaking peripheral beside the port block.
`timescale 1ns/1ps
`default_nettype none
module ppc_peer_model (
   input wire logic clk,
   input wire logic slow,
   input wire ppc_pkg::ppc_latch_s want_latch,
   input wire logic [6:0] want_lines,
   output ppc_pkg::ppc_latch_s latch_empty,
   output logic second_status,
   output logic first_hs_req,
   output logic [3:0] source_pending,
   output logic port_irq_ack_in
);
   import ppc_pkg::*;
   // ------------------------------------------------------------
   // Line levels
   // ------------------------------------------------------------
   // A slow peer settles one cycle later, so the block never relies on
   // a change showing up at a fixed edge after software asked for it.
   ppc_latch_s lat_q;
   logic [6:0] line_q;
   always @(posedge clk) begin
      lat_q <= want_latch;
      line_q <= want_lines;
      latch_empty <= slow ? lat_q : want_latch;
      {port_irq_ack_in, source_pending, first_hs_req, second_status} <=
         slow ? line_q : want_lines;
   end
endmodule
`default_nettype wire

// ===== ppc_pkg.sv
// Shared constants, field layouts and state type of the port config block.
`default_nettype none
package ppc_pkg;

   // ------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ------------------------------------------------------------
   localparam logic [4:0] IDX_GEN = 5'h00;
   localparam logic [4:0] IDX_SRQ = 5'h01;
   localparam logic [4:0] IDX_ADIR = 5'h02;
   localparam logic [4:0] IDX_BDIR = 5'h03;
   localparam logic [4:0] IDX_CDIR = 5'h04;
   localparam logic [4:0] IDX_VEC = 5'h05;
   localparam logic [4:0] IDX_ACR = 5'h06;
   localparam int IDX_MSB = 6;
   localparam int IDX_LSB = 2;

   // ------------------------------------------------------------
   // Reset values and encodings.
   // ------------------------------------------------------------
   localparam logic [7:0] VEC_RESET = 8'h0F;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] MODE_0 = 2'h0;
   localparam logic [1:0] MODE_1 = 2'h1;
   localparam logic [1:0] MODE_2 = 2'h2;
   localparam logic [1:0] MODE_3 = 2'h3;
   localparam logic [1:0] SUB_00 = 2'h0;
   localparam logic [1:0] SUB_01 = 2'h1;
   localparam logic [1:0] SVC_DMA_H1 = 2'h2;
   localparam logic [1:0] SRC_1 = 2'h0;
   localparam logic [1:0] SRC_2 = 2'h1;
   localparam logic [1:0] SRC_3 = 2'h2;
   localparam logic [1:0] SRC_4 = 2'h3;

   typedef enum logic [2:0] {
      H2_STATUS_IN, H2_OUT_NEGATED, H2_OUT_ASSERTED, H2_ILK_IN,
      H2_PULSE_IN, H2_ILK_OUT, H2_PULSE_OUT
   } ppc_h2_mode_e;

   // ------------------------------------------------------------
   // Register, peer input, pin and state field layouts, msb first.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [1:0] mode;
      logic [5:0] other;
   } ppc_gcr_s;

   typedef struct packed {
      logic rsvd;
      logic [1:0] svc_sel;
      logic ack_fn;
      logic irq_fn;
      logic [2:0] prio;
   } ppc_srq_s;

   typedef struct packed {
      logic [1:0] sub;
      logic [2:0] h2_ctl;
      logic h2_irq_en;
      logic svc_en;
      logic stat_mode;
   } ppc_acr_s;

   typedef struct packed {
      logic [1:0] a_empty;
      logic [1:0] b_empty;
   } ppc_latch_s;

   typedef struct packed {
      logic [7:0] a_dir;
      logic [7:0] b_dir;
      logic [7:0] c_dir;
      logic c5_irq_fn;
      logic c6_ack_fn;
      ppc_h2_mode_e h2_mode;
      logic first_status;
   } ppc_pins_s;

   typedef struct packed {
      logic wr_pend;
      logic [4:0] wr_idx;
      ppc_gcr_s gen;
      ppc_srq_s srq;
      logic [7:0] adir;
      logic [7:0] bdir;
      logic [7:0] cdir;
      ppc_acr_s acr;
      logic [5:0] vec_up;
      logic vec_wr;
      logic [31:0] rdata;
      logic rdy;
      logic [2:0] ack_sync;
      logic ack_lvl;
      logic st_prev;
      ppc_pins_s pins;
      logic [7:0] prio;
      logic irq1;
      logic dma1;
      logic irq2;
      logic [7:0] vec_out;
      logic vec_vld;
   } ppc_state_s;

endpackage
`default_nettype wire

// ===== ppc_regs.sv
// Port configuration registers behind an AHB-Lite slave.
`timescale 1ns/1ps
`default_nettype none

module ppc_regs (
   input wire logic clk,
   input wire logic reset,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire ppc_pkg::ppc_latch_s latch_empty,
   input wire logic second_status,
   input wire logic first_hs_req,
   input wire logic [3:0] source_pending,
   input wire logic port_irq_ack_in,
   output ppc_pkg::ppc_pins_s pin_cfg,
   output logic [7:0] prio_order,
   output logic second_irq,
   output logic first_irq,
   output logic first_dma_req,
   output logic [7:0] ack_vector,
   output logic ack_vector_valid
);
   import ppc_pkg::*;

   ppc_state_s s_reg;
   ppc_state_s s_next;
   logic acc;
   logic [4:0] idx;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------

   // Highest priority code sits in bits 7:6.
   function automatic logic [7:0] prio_fn(input logic [2:0] p);
      logic [3:0] hi;
      logic [3:0] lo;
      hi = p[0] ? {SRC_2, SRC_1} : {SRC_1, SRC_2};
      lo = p[1] ? {SRC_4, SRC_3} : {SRC_3, SRC_4};
      prio_fn = p[2] ? {lo, hi} : {hi, lo};
   endfunction

   // Walks lowest to highest so the highest pending source wins.
   function automatic logic [1:0] pick(
      input logic [7:0] ord,
      input logic [3:0] pend
   );
      logic [1:0] c;
      pick = ord[7:6];
      for (int i = 0; i < 4; i++) begin
         c = ord[2*i +: 2];
         if (pend[c]) begin
            pick = c;
         end
      end
   endfunction

   function automatic logic status_fn(
      input logic [1:0] empty,
      input logic both
   );
      status_fn = both ? &empty : |empty;
   endfunction

   function automatic logic [7:0] rd_mux(
      input ppc_state_s s,
      input logic [4:0] i
   );
      case (i)
         IDX_GEN: rd_mux = s.gen;
         IDX_SRQ: rd_mux = s.srq;
         IDX_ADIR: rd_mux = s.adir;
         IDX_BDIR: rd_mux = s.bdir;
         IDX_CDIR: rd_mux = s.cdir;
         IDX_VEC: rd_mux = s.vec_wr ? {s.vec_up, 2'b00} : VEC_RESET;
         IDX_ACR: rd_mux = s.acr;
         default: rd_mux = 8'h00;
      endcase
   endfunction

   function automatic ppc_h2_mode_e h2_fn(
      input logic [1:0] mode,
      input ppc_acr_s a
   );
      logic [2:0] c;
      c = a.h2_ctl;
      h2_fn = H2_STATUS_IN;
      case (mode)
         MODE_0: begin
            if (!c[2]) begin
               h2_fn = H2_STATUS_IN;
            end else if (a.sub[1] || !c[1]) begin
               h2_fn = c[0] ? H2_OUT_ASSERTED : H2_OUT_NEGATED;
            end else if (a.sub == SUB_01) begin
               h2_fn = c[0] ? H2_PULSE_OUT : H2_ILK_OUT;
            end else begin
               h2_fn = c[0] ? H2_PULSE_IN : H2_ILK_IN;
            end
         end
         MODE_1: begin
            if (!c[2]) begin
               h2_fn = H2_STATUS_IN;
            end else begin
               h2_fn = c[0] ? H2_OUT_ASSERTED : H2_OUT_NEGATED;
            end
         end
         MODE_2: begin
            h2_fn = c[0] ? H2_PULSE_OUT : H2_ILK_OUT;
         end
         default: h2_fn = H2_STATUS_IN;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   assign acc = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign idx = haddr[IDX_MSB:IDX_LSB];

   always_comb begin
      s_next = s_reg;
      // Data phase of a write lands here; read data below sees it,
      // so a read right behind a write returns the new value.
      if (s_reg.wr_pend) begin
         // written bits are kept, except srq.rsvd and the two low vector bits
         case (s_reg.wr_idx)
            IDX_GEN: s_next.gen = ppc_gcr_s'(hwdata[7:0]);
            IDX_SRQ: begin
               s_next.srq = ppc_srq_s'(hwdata[7:0]);
               s_next.srq.rsvd = 1'b0;
            end
            IDX_ADIR: s_next.adir = hwdata[7:0];
            IDX_BDIR: s_next.bdir = hwdata[7:0];
            IDX_CDIR: s_next.cdir = hwdata[7:0];
            IDX_VEC: begin
               s_next.vec_up = hwdata[7:2];
               s_next.vec_wr = 1'b1;
            end
            IDX_ACR: s_next.acr = ppc_acr_s'(hwdata[7:0]);
            default: ;
         endcase
      end
      s_next.wr_pend = acc && hwrite;
      s_next.wr_idx = idx;
      s_next.rdy = 1'b1;
      // read path muxes next-state values, so it sees this cycle's write
      if (acc && !hwrite) begin
         s_next.rdata = {24'h000000, rd_mux(s_next, idx)};
      end else begin
         s_next.rdata = 32'h00000000;
      end

      // The acknowledge pin is asynchronous; a level counts only
      // once the second and third stages agree.
      s_next.ack_sync = {s_reg.ack_sync[1:0], port_irq_ack_in};
      if (s_reg.ack_sync[1] == s_reg.ack_sync[2]) begin
         s_next.ack_lvl = s_reg.ack_sync[2];
      end
      s_next.vec_vld = s_next.ack_lvl && !s_reg.ack_lvl &&
                       s_reg.srq.ack_fn;
      if (s_next.vec_vld) begin
         s_next.vec_out = {s_reg.vec_up,
                           pick(s_reg.prio, source_pending)};
      end

      // port A direction off in mode 3
      if (s_reg.gen.mode == MODE_3) begin
         s_next.pins.a_dir = 8'h00;
      end else begin
         s_next.pins.a_dir = s_reg.adir;
      end
      // port B direction off in modes 2 and 3
      if (s_reg.gen.mode == MODE_2 || s_reg.gen.mode == MODE_3) begin
         s_next.pins.b_dir = 8'h00;
      end else begin
         s_next.pins.b_dir = s_reg.bdir;
      end
      s_next.pins.c_dir = s_reg.cdir;
      s_next.pins.c5_irq_fn = s_reg.srq.irq_fn;
      s_next.pins.c6_ack_fn = s_reg.srq.ack_fn;
      s_next.pins.h2_mode = h2_fn(s_reg.gen.mode, s_reg.acr);
      s_next.pins.first_status = 1'b0;
      if (s_reg.gen.mode == MODE_0 && s_reg.acr.sub == SUB_01) begin
         s_next.pins.first_status =
            status_fn(latch_empty.a_empty, s_reg.acr.stat_mode);
      end else if (s_reg.gen.mode == MODE_2) begin
         s_next.pins.first_status =
            status_fn(latch_empty.b_empty, s_reg.acr.stat_mode);
      end
      s_next.prio = prio_fn(s_reg.srq.prio);

      s_next.st_prev = second_status;
      s_next.irq2 = second_status && !s_reg.st_prev &&
                    s_reg.acr.h2_irq_en;
      s_next.dma1 = first_hs_req && s_reg.acr.svc_en &&
                    (s_reg.srq.svc_sel == SVC_DMA_H1);
      s_next.irq1 = first_hs_req && s_reg.acr.svc_en &&
                    (s_reg.srq.svc_sel != SVC_DMA_H1);
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_reg <= '0;
         s_reg.vec_up <= VEC_RESET[7:2];
         s_reg.rdy <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign hreadyout = s_reg.rdy;
   assign hresp = 1'b0;
   assign hrdata = s_reg.rdata;
   assign pin_cfg = s_reg.pins;
   assign prio_order = s_reg.prio;
   assign second_irq = s_reg.irq2;
   assign first_irq = s_reg.irq1;
   assign first_dma_req = s_reg.dma1;
   assign ack_vector = s_reg.vec_out;
   assign ack_vector_valid = s_reg.vec_vld;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_wr(logic [4:0] i);
      acc && hwrite && idx == i;
   endsequence

   sequence s_rd(logic [4:0] i);
      acc && !hwrite && idx == i;
   endsequence

   a_vec_unwritten: assert property (
      s_rd(IDX_VEC) ##0 (!s_reg.vec_wr && !s_reg.wr_pend)
      |=> hrdata == {24'h000000, VEC_RESET})
      else $error("vector read before write is not 0F");

   a_vec_written: assert property (
      s_wr(IDX_VEC) ##1 !acc ##1 s_rd(IDX_VEC)
      |=> hrdata[1:0] == 2'b00 && hrdata[7:2] == $past(hwdata[7:2], 2))
      else $error("vector read back wrong after write");

   a_cdir_follow: assert property (
      s_wr(IDX_CDIR) |=> ##2 pin_cfg.c_dir == $past(hwdata[7:0], 2))
      else $error("port C direction does not follow write");

   a_adir_mode3: assert property (
      s_reg.gen.mode == MODE_3 |=> pin_cfg.a_dir == 8'h00)
      else $error("port A direction active in mode 3");

   a_bdir_mode23: assert property (
      s_reg.gen.mode[1] |=> pin_cfg.b_dir == 8'h00)
      else $error("port B direction active in mode 2 or 3");

   a_h2_irq_on: assert property (
      $rose(second_status) && s_reg.acr.h2_irq_en |=> second_irq)
      else $error("second status rise gave no interrupt");

   a_h2_irq_off: assert property (
      !s_reg.acr.h2_irq_en |=> !second_irq)
      else $error("second interrupt while disabled");

   a_svc_gate: assert property (
      !s_reg.acr.svc_en |=> !first_irq && !first_dma_req)
      else $error("first handshake request while disabled");

   a_prio_swap: assert property (
      s_reg.srq.prio == 3'h5 |=>
      prio_order == {SRC_3, SRC_4, SRC_2, SRC_1})
      else $error("priority order wrong for code 5");

   a_pc5_select: assert property (
      s_reg.srq.irq_fn |=> pin_cfg.c5_irq_fn)
      else $error("port C bit 5 not routed to irq");

   a_mode2_pulse: assert property (
      s_reg.gen.mode == MODE_2 && s_reg.acr.h2_ctl[0]
      |=> pin_cfg.h2_mode == H2_PULSE_OUT)
      else $error("mode 2 pulsed handshake not selected");

   a_status_both: assert property (
      s_reg.gen.mode == MODE_0 && s_reg.acr.sub == SUB_01 &&
      s_reg.acr.stat_mode
      |=> pin_cfg.first_status == &$past(latch_empty.a_empty))
      else $error("first status wrong in both-empty mode");

   a_ack_vector: assert property (
      ack_vector_valid |-> ack_vector[7:2] == $past(s_reg.vec_up))
      else $error("acknowledge vector upper bits wrong");

endmodule
`default_nettype wire

// ===== test_parallel_port_config_regs.sv
// Self-checking testbench of the port configuration registers.
`timescale 1ns/1ps
`default_nettype none
module test_parallel_port_config_regs;
   import ppc_pkg::*;
   typedef struct packed {
      logic [6:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } ppc_row_s;
   typedef struct packed {
      logic [1:0] m;
      logic [7:0] c;
      logic [2:0] h;
   } ppc_h2_row_s;
   logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   ppc_latch_s latch_empty, want_latch;
   logic second_status, first_hs_req, port_irq_ack_in;
   logic [3:0] source_pending, p_pend;
   logic p_ack, p_req, p_st2, slow;
   ppc_pins_s pin_cfg;
   logic [7:0] prio_order, ack_vector;
   logic second_irq, first_irq, first_dma_req, ack_vector_valid;
   int fail_count = 0;
   int n_checks = 0;
   int irq2_n = 0;
   int ackv_n = 0;
   int n;
   ppc_row_s rows[8] = '{{IDX_SRQ, 2'h0, 8'hFF, 8'h7F},
      {IDX_ADIR, 2'h0, 8'hA5, 8'hA5}, {IDX_BDIR, 2'h0, 8'h5A, 8'h5A},
      {IDX_CDIR, 2'h0, 8'h3C, 8'h3C}, {IDX_VEC, 2'h0, 8'hFF, 8'hFC},
      {IDX_ACR, 2'h0, 8'hFF, 8'hFF}, {5'h07, 2'h0, 8'hFF, 8'h00},
      {IDX_GEN, 2'h0, 8'h80, 8'h80}};
   ppc_h2_row_s h2_rows[14] = '{{2'h0, 8'h00, 3'h0}, {2'h0, 8'h20, 3'h1},
      {2'h0, 8'h28, 3'h2}, {2'h0, 8'h30, 3'h3}, {2'h0, 8'h38, 3'h4},
      {2'h0, 8'h70, 3'h5}, {2'h0, 8'h78, 3'h6}, {2'h0, 8'hB8, 3'h2},
      {2'h0, 8'hB0, 3'h1}, {2'h1, 8'h28, 3'h2}, {2'h1, 8'h30, 3'h1},
      {2'h1, 8'h10, 3'h0}, {2'h2, 8'h29, 3'h6}, {2'h2, 8'h30, 3'h5}};

   assign hready = hreadyout;

   ppc_regs ppc_regs_inst (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .latch_empty,
      .second_status, .first_hs_req, .source_pending, .port_irq_ack_in,
      .pin_cfg, .prio_order, .second_irq, .first_irq, .first_dma_req,
      .ack_vector, .ack_vector_valid);

   ppc_peer_model ppc_peer_model_inst (.clk, .slow, .want_latch,
      .want_lines({p_ack, p_pend, p_req, p_st2}), .latch_empty,
      .second_status, .first_hs_req, .source_pending, .port_irq_ack_in);

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      if (second_irq === 1'b1) irq2_n++;
      if (ack_vector_valid === 1'b1) ackv_n++;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   // A slave that never answers ends the run instead of hanging it.
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         chk("hreadyout", 32'h1, {31'h0, hreadyout});
         test_done;
      end
   endtask

   task automatic bus(input logic w, input logic [6:0] a,
                      input logic [7:0] d);
      hsel <= 1'b1;
      haddr <= {25'h0, a};
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      wait_rdy;
      rd = hrdata;
   endtask

   task automatic settle;
      repeat (5) @(posedge clk);
   endtask

   function automatic logic [7:0] pexp(input logic [2:0] p);
      logic [3:0] f, s;
      f = p[0] ? 4'h4 : 4'h1;
      s = p[1] ? 4'hE : 4'hB;
      return p[2] ? {s, f} : {f, s};
   endfunction

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      want_latch = '0;
      {p_ack, p_pend, p_req, p_st2, slow} = 8'h00;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         bus(1'b0, {i[4:0], 2'h0}, 8'h0);
         chk("reset read", (i[4:0] === IDX_VEC) ? 32'h0F : 32'h0,
             rd);
      end
      chk("pin dirs", 32'h0, {pin_cfg.a_dir, pin_cfg.c_dir});
      chk("hresp", 32'h0, {31'h0, hresp});
      foreach (rows[i]) begin
         bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 8'h0);
         chk("read back", {24'h0, rows[i].e}, rd);
      end
      settle;
      chk("a_dir", 32'hA5, pin_cfg.a_dir);
      chk("b_dir in mode 2", 32'h0, pin_cfg.b_dir);
      chk("pin functions", 32'h3,
          {pin_cfg.c5_irq_fn, pin_cfg.c6_ack_fn});
      bus(1'b1, {IDX_GEN, 2'h0}, 8'hC0);
      settle;
      chk("c_dir in mode 3", 32'h3C, pin_cfg.c_dir);
      chk("dirs in mode 3", 32'h0,
          {pin_cfg.a_dir, pin_cfg.b_dir});
      for (int i = 1; i < 3; i++) begin
         bus(1'b1, {IDX_SRQ, 2'h0}, {3'h0, i[1:0], 3'h0});
         settle;
         chk("pin functions", {i[0], i[1]},
             {pin_cfg.c5_irq_fn, pin_cfg.c6_ack_fn});
      end
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, {IDX_SRQ, 2'h0}, {5'h0, i[2:0]});
         settle;
         chk("prio_order", pexp(i[2:0]), prio_order);
      end
      foreach (h2_rows[i]) begin
         bus(1'b1, {IDX_GEN, 2'h0}, {h2_rows[i].m, 6'h0});
         bus(1'b1, {IDX_ACR, 2'h0}, h2_rows[i].c);
         settle;
         chk("h2_mode", h2_rows[i].h,
             pin_cfg.h2_mode);
         chk("dirs", {(h2_rows[i].m[1] ? 8'h00 : 8'h5A), 8'hA5},
             {pin_cfg.b_dir, pin_cfg.a_dir});
      end
      for (int i = 0; i < 16; i++) begin
         bus(1'b1, {IDX_GEN, 2'h0}, i[3] ? 8'h80 : 8'h00);
         bus(1'b1, {IDX_ACR, 2'h0}, {7'h20, i[2]});
         want_latch <= i[3] ? {~i[1:0], i[1:0]} : {i[1:0], ~i[1:0]};
         slow <= i[0];
         settle;
         chk("first_status", i[2] ? (i[1:0] == 2'h3) : (i[1:0] != 2'h0),
             pin_cfg.first_status);
      end
      for (int i = 0; i < 2; i++) begin
         bus(1'b1, {IDX_ACR, 2'h0}, {5'h0, i[0], 2'h0});
         p_st2 <= 1'b0;
         settle;
         n = irq2_n;
         p_st2 <= 1'b1;
         settle;
         chk("second_irq pulses", i, irq2_n - n);
      end
      p_req <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, {IDX_SRQ, 2'h0}, i[1] ? 8'h40 : 8'h00);
         bus(1'b1, {IDX_ACR, 2'h0}, {6'h0, i[0], 1'b0});
         settle;
         chk("first requests", {i[0] & i[1], i[0] & ~i[1]},
             {first_dma_req, first_irq});
      end
      bus(1'b1, {IDX_SRQ, 2'h0}, 8'h10);
      bus(1'b1, {IDX_VEC, 2'h0}, 8'hA5);
      p_pend <= 4'b0100;
      n = ackv_n;
      bus(1'b0, {IDX_VEC, 2'h0}, 8'h0);
      settle;
      chk("vector read", 32'hA4, rd);
      chk("ack pulses", 32'h0, ackv_n - n);
      p_ack <= 1'b1;
      repeat (20) if (ackv_n == n) @(posedge clk);
      chk("ack pulses", 32'h1, ackv_n - n);
      chk("ack_vector", 32'hA6, ack_vector);
      test_done;
   end
endmodule
`default_nettype wire
